// ==== hw/irq_prio_pkg.sv ====
package irq_prio_pkg;

	// Register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// Register addresses
	localparam logic [7:0] ADR_STATUS_WORD = 8'h00;
	localparam logic [7:0] ADR_CORE_CTRL   = 8'h01;
	localparam logic [7:0] ADR_GCTRL_ONE   = 8'h02;
	localparam logic [7:0] ADR_GCTRL_TWO   = 8'h03;
	localparam logic [7:0] ADR_FLAG_BASE   = 8'h04;
	localparam logic [7:0] ADR_ENABLE_BASE = 8'h06;
	localparam logic [7:0] ADR_PRIO_BASE   = 8'h08;
	localparam logic [7:0] ADR_EVT_STATUS  = 8'h10;
	localparam logic [7:0] ADR_EVT_MASK    = 8'h11;

	// Field positions
	localparam int LEVEL_LSB  = 5;
	localparam int LEVEL_W    = 3;
	localparam int EXT_BIT    = 3;
	localparam int NEST_BIT   = 15;
	localparam int TRAP_LSB   = 1;
	localparam int TRAP_W     = 4;
	localparam int ALT_BIT    = 15;
	localparam int DINSTR_BIT = 14;
	localparam int POL_W      = 3;
	localparam int FLAGS_PER  = 16;
	localparam int PRIO_PER   = 4;
	localparam int PRIO_PITCH = 4;
	localparam int EVT_W      = TRAP_W + POL_W;

	// Source positions of the external request pins
	localparam int EXT_SRC0 = 0;
	localparam int EXT_SRC1 = 20;
	localparam int EXT_SRC2 = 29;

	// Reset values
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [2:0]  RST_LEVEL = 3'h0;
	localparam logic [2:0]  RST_PRIO  = 3'h0;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

	typedef struct packed {
		logic       pending;
		logic [6:0] vector;
		logic [2:0] level;
	} dispatch_t;

endpackage : irq_prio_pkg

// ==== hw/interrupt_priority_control.sv ====
`timescale 1ns/1ns
module interrupt_priority_control #(
	parameter int NUM_SRC = 32
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rst_n,
	input  wire irq_prio_pkg::bus_req_t  bus,
	input  wire logic [NUM_SRC-1:0]      srcReq,
	input  wire logic [2:0]              extPin,
	input  wire logic [3:0]              trapEvt,
	input  wire logic                    cpuLevelWr,
	input  wire logic [3:0]              cpuLevelIn,
	input  wire logic                    disableInstrActive,
	output irq_prio_pkg::dispatch_t      dispatch_q,
	output logic [15:0]                  rdData_q,
	output logic                         irq_q,
	output logic                         altTable_q,
	output logic                         nestDisable_q
);

	localparam int NUM_WORDS = NUM_SRC / irq_prio_pkg::FLAGS_PER;
	localparam int NUM_PRIO  = NUM_SRC / irq_prio_pkg::PRIO_PER;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = (a == target);
	endfunction : hit

	logic [2:0]               levelLow_q;
	logic                     levelExt_q;
	logic [3:0]               trapStatus_q;
	logic [2:0]               polarity_q;
	logic [2:0]               extPrev_q;
	logic                     primed_q;
	logic [NUM_SRC-1:0]       flag_q;
	logic [NUM_SRC-1:0]       enable_q;
	logic [2:0]               prio_q [NUM_SRC];
	logic [6:0]               evtStatus_q;
	logic [6:0]               evtMask_q;
	logic [6:0]               evtStatus_d;
	logic [6:0]               evtMask_d;
	logic [2:0]               extEdge;
	logic [NUM_SRC-1:0]       srcSet;
	logic [3:0]               cpuLevel;
	logic [15:0]              prioWord [NUM_PRIO];
	logic [15:0]              rdMux;
	logic                     anyElig;
	logic [6:0]               bestVec;
	logic [2:0]               bestPrio;

	assign cpuLevel = {levelExt_q, levelLow_q};

	// External pin edge detection, armed one cycle after reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			extPrev_q <= 3'h0;
			primed_q  <= 1'b0;
		end else begin
			extPrev_q <= extPin;
			primed_q  <= 1'b1;
		end
	end

	always_comb begin
		for (int p = 0; p < irq_prio_pkg::POL_W; p++) begin
			if (polarity_q[p]) begin
				extEdge[p] = primed_q & extPrev_q[p] & ~extPin[p];
			end else begin
				extEdge[p] = primed_q & ~extPrev_q[p] & extPin[p];
			end
		end
	end

	always_comb begin
		srcSet = srcReq;
		srcSet[irq_prio_pkg::EXT_SRC0] = srcReq[irq_prio_pkg::EXT_SRC0] | extEdge[0];
		srcSet[irq_prio_pkg::EXT_SRC1] = srcReq[irq_prio_pkg::EXT_SRC1] | extEdge[1];
		srcSet[irq_prio_pkg::EXT_SRC2] = srcReq[irq_prio_pkg::EXT_SRC2] | extEdge[2];
	end

	// Per-source flag, enable and priority storage
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_src
			localparam int WRD = g / irq_prio_pkg::FLAGS_PER;
			localparam int BT  = g % irq_prio_pkg::FLAGS_PER;
			localparam int PRG = g / irq_prio_pkg::PRIO_PER;
			localparam int FLD = (g % irq_prio_pkg::PRIO_PER) * irq_prio_pkg::PRIO_PITCH;
			logic wrFlag;
			logic wrEn;
			logic wrPrio;
			assign wrFlag = bus.wr && hit(bus.addr, irq_prio_pkg::ADR_FLAG_BASE + 8'(WRD));
			assign wrEn   = bus.wr && hit(bus.addr, irq_prio_pkg::ADR_ENABLE_BASE + 8'(WRD));
			assign wrPrio = bus.wr && hit(bus.addr, irq_prio_pkg::ADR_PRIO_BASE + 8'(PRG));

			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					flag_q[g] <= 1'b0;
				end else if (srcSet[g]) begin
					flag_q[g] <= 1'b1;
				end else if (wrFlag) begin
					flag_q[g] <= bus.wdata[BT];
				end
			end

			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					enable_q[g] <= 1'b0;
				end else if (wrEn) begin
					enable_q[g] <= bus.wdata[BT];
				end
			end

			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					prio_q[g] <= irq_prio_pkg::RST_PRIO;
				end else if (wrPrio) begin
					prio_q[g] <= bus.wdata[FLD +: 3];
				end
			end
		end
	endgenerate

	always_comb begin
		for (int k = 0; k < NUM_PRIO; k++) begin
			prioWord[k] = irq_prio_pkg::RST_WORD;
			for (int f = 0; f < irq_prio_pkg::PRIO_PER; f++) begin
				prioWord[k][f*irq_prio_pkg::PRIO_PITCH +: 3] = prio_q[k*irq_prio_pkg::PRIO_PER + f];
			end
		end
	end

	// CPU level, low field and extension bit
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			levelLow_q <= irq_prio_pkg::RST_LEVEL;
		end else if (cpuLevelWr) begin
			levelLow_q <= cpuLevelIn[2:0];
		end else if (bus.wr && hit(bus.addr, irq_prio_pkg::ADR_STATUS_WORD)
				&& !nestDisable_q) begin
			levelLow_q <= bus.wdata[irq_prio_pkg::LEVEL_LSB +: 3];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			levelExt_q <= 1'b0;
		end else if (cpuLevelWr) begin
			levelExt_q <= cpuLevelIn[3];
		end else if (bus.wr && hit(bus.addr, irq_prio_pkg::ADR_CORE_CTRL)
				&& !bus.wdata[irq_prio_pkg::EXT_BIT]) begin
			levelExt_q <= 1'b0;
		end
	end

	// Global control one
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			nestDisable_q <= 1'b0;
		end else if (bus.wr && hit(bus.addr, irq_prio_pkg::ADR_GCTRL_ONE)) begin
			nestDisable_q <= bus.wdata[irq_prio_pkg::NEST_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			trapStatus_q <= 4'h0;
		end else begin
			if (bus.wr && hit(bus.addr, irq_prio_pkg::ADR_GCTRL_ONE)) begin
				trapStatus_q <= bus.wdata[irq_prio_pkg::TRAP_LSB +: 4] | trapEvt;
			end else begin
				trapStatus_q <= trapStatus_q | trapEvt;
			end
		end
	end

	// Global control two
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			altTable_q <= 1'b0;
			polarity_q <= 3'h0;
		end else if (bus.wr && hit(bus.addr, irq_prio_pkg::ADR_GCTRL_TWO)) begin
			altTable_q <= bus.wdata[irq_prio_pkg::ALT_BIT];
			polarity_q <= bus.wdata[2:0];
		end
	end

	// Event status, cleared by read, a new event wins
	always_comb begin
		evtStatus_d = evtStatus_q;
		if (bus.rd && hit(bus.addr, irq_prio_pkg::ADR_EVT_STATUS)) begin
			evtStatus_d = 7'h00;
		end
		evtStatus_d = evtStatus_d | {extEdge, trapEvt};
		evtMask_d = evtMask_q;
		if (bus.wr && hit(bus.addr, irq_prio_pkg::ADR_EVT_MASK)) begin
			evtMask_d = bus.wdata[irq_prio_pkg::EVT_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			evtStatus_q <= 7'h00;
			evtMask_q   <= 7'h00;
			irq_q       <= 1'b0;
		end else begin
			evtStatus_q <= evtStatus_d;
			evtMask_q   <= evtMask_d;
			irq_q       <= |(evtStatus_d & evtMask_d);
		end
	end

	// Highest priority eligible source, ties to lowest vector
	always_comb begin
		anyElig  = 1'b0;
		bestVec  = 7'h00;
		bestPrio = 3'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (flag_q[i] && enable_q[i] && ({1'b0, prio_q[i]} > cpuLevel)
					&& (!anyElig || prio_q[i] >= bestPrio)) begin
				anyElig  = 1'b1;
				bestVec  = 7'(i);
				bestPrio = prio_q[i];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dispatch_q <= '0;
		end else begin
			dispatch_q.pending <= anyElig;
			dispatch_q.vector  <= bestVec;
			dispatch_q.level   <= bestPrio;
		end
	end

	// Read path, unimplemented bits and addresses read as zero
	always_comb begin
		rdMux = irq_prio_pkg::RST_WORD;
		case (bus.addr)
			irq_prio_pkg::ADR_STATUS_WORD: rdMux[irq_prio_pkg::LEVEL_LSB +: 3] = levelLow_q;
			irq_prio_pkg::ADR_CORE_CTRL:   rdMux[irq_prio_pkg::EXT_BIT] = levelExt_q;
			irq_prio_pkg::ADR_GCTRL_ONE: begin
				rdMux[irq_prio_pkg::NEST_BIT] = nestDisable_q;
				rdMux[irq_prio_pkg::TRAP_LSB +: 4] = trapStatus_q;
			end
			irq_prio_pkg::ADR_GCTRL_TWO: begin
				rdMux[irq_prio_pkg::ALT_BIT]  = altTable_q;
				rdMux[irq_prio_pkg::DINSTR_BIT] = disableInstrActive;
				rdMux[2:0] = polarity_q;
			end
			irq_prio_pkg::ADR_EVT_STATUS: rdMux[irq_prio_pkg::EVT_W-1:0] = evtStatus_q;
			irq_prio_pkg::ADR_EVT_MASK:   rdMux[irq_prio_pkg::EVT_W-1:0] = evtMask_q;
			default: begin
				for (int k = 0; k < NUM_WORDS; k++) begin
					if (hit(bus.addr, irq_prio_pkg::ADR_FLAG_BASE + 8'(k))) begin
						rdMux = flag_q[k*16 +: 16];
					end
					if (hit(bus.addr, irq_prio_pkg::ADR_ENABLE_BASE + 8'(k))) begin
						rdMux = enable_q[k*16 +: 16];
					end
				end
				for (int k = 0; k < NUM_PRIO; k++) begin
					if (hit(bus.addr, irq_prio_pkg::ADR_PRIO_BASE + 8'(k))) begin
						rdMux = prioWord[k];
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdData_q <= irq_prio_pkg::RST_WORD;
		end else if (bus.rd) begin
			rdData_q <= rdMux;
		end else begin
			rdData_q <= irq_prio_pkg::RST_WORD;
		end
	end

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence sStatusRead;
		bus.rd && hit(bus.addr, irq_prio_pkg::ADR_EVT_STATUS) && trapEvt == 4'h0 && extEdge == 3'h0;
	endsequence

	sequence sLockedWrite;
		nestDisable_q && !cpuLevelWr && bus.wr && hit(bus.addr, irq_prio_pkg::ADR_STATUS_WORD);
	endsequence

	sequence sPrioZeroWrite;
		bus.wr && hit(bus.addr, irq_prio_pkg::ADR_PRIO_BASE);
	endsequence

	a_flag_sets_sticky: assert property (
		(srcReq != '0) |=> ((flag_q & $past(srcReq)) == $past(srcReq)))
		else $error("request flag not set after source request");

	a_pend_needs_elig: assert property (
		dispatch_q.pending |-> |($past(flag_q & enable_q) & (NUM_SRC'(1) << dispatch_q.vector)))
		else $error("pending raised without eligible source");

	a_pend_above_level: assert property (
		dispatch_q.pending |-> ({1'b0, dispatch_q.level} > $past(cpuLevel)))
		else $error("pending priority not above cpu level");

	a_low_field_locked: assert property (
		sLockedWrite |=> $stable(levelLow_q))
		else $error("cpu level changed while nesting disabled");

	a_ext_never_set: assert property (
		(!levelExt_q && !cpuLevelWr) |=> !levelExt_q)
		else $error("extension bit set by software");

	a_trap_sets_status: assert property (
		(trapEvt != 4'h0) |=> ((trapStatus_q & $past(trapEvt)) == $past(trapEvt)))
		else $error("trap status not set");

	a_reserved_reads_zero: assert property (
		(bus.rd && hit(bus.addr, irq_prio_pkg::ADR_GCTRL_ONE)) |=>
		(rdData_q[14:5] == 10'h000 && rdData_q[0] == 1'b0))
		else $error("unimplemented bits read nonzero");

	a_status_read_clear: assert property (
		sStatusRead |=> (evtStatus_q == 7'h00) && !irq_q)
		else $error("event status not cleared by read");

	a_edge_sets_flag: assert property (
		extEdge[0] |=> flag_q[irq_prio_pkg::EXT_SRC0])
		else $error("external edge did not set flag");

	a_prio_zero_write: assert property (
		sPrioZeroWrite |=> (prio_q[0] == $past(bus.wdata[2:0])))
		else $error("priority field of vector zero not written");

	sequence sTrapWrite;
		bus.wr && hit(bus.addr, irq_prio_pkg::ADR_GCTRL_ONE) && trapEvt == 4'h0;
	endsequence

	sequence sCtrlTwoRead;
		bus.rd && hit(bus.addr, irq_prio_pkg::ADR_GCTRL_TWO);
	endsequence

	a_trap_sw_write: assert property (
		sTrapWrite |=> (trapStatus_q == $past(bus.wdata[irq_prio_pkg::TRAP_LSB +: 4])))
		else $error("trap status not written by software");

	a_alt_table_write: assert property (
		(bus.wr && hit(bus.addr, irq_prio_pkg::ADR_GCTRL_TWO)) |=>
		(altTable_q == $past(bus.wdata[irq_prio_pkg::ALT_BIT])))
		else $error("alternate table select not written");

	a_disable_instr_read: assert property (
		sCtrlTwoRead |=> (rdData_q[irq_prio_pkg::DINSTR_BIT] == $past(disableInstrActive)
		&& rdData_q[13:3] == 11'h000))
		else $error("control two read data wrong");

	a_core_level_load: assert property (
		cpuLevelWr |=> (cpuLevel == $past(cpuLevelIn)))
		else $error("core level load lost");

	a_ext_clear_write: assert property (
		(bus.wr && hit(bus.addr, irq_prio_pkg::ADR_CORE_CTRL)
		&& !bus.wdata[irq_prio_pkg::EXT_BIT] && !cpuLevelWr) |=> !levelExt_q)
		else $error("extension bit not cleared");

	a_read_idle_zero: assert property (
		!bus.rd |=> (rdData_q == 16'h0000))
		else $error("read data not zero outside read");

endmodule : interrupt_priority_control

// ==== dv/cpu_periph_model.sv ====
`timescale 1ns/1ns
module cpu_periph_model (
	input  wire logic        sys_clk,
	output logic [31:0]      srcReq,
	output logic [3:0]       trapEvt,
	output logic             cpuLevelWr,
	output logic [3:0]       cpuLevelIn,
	output logic             disableInstrActive,
	output logic [2:0]       extPin
);
	initial begin
		srcReq = '0;
		trapEvt = '0;
		cpuLevelWr = 1'b0;
		cpuLevelIn = 4'h0;
		disableInstrActive = 1'b0;
		extPin = 3'h0;
	end

	// One-cycle request pulses from peripherals and trap logic
	task automatic pulse(input logic [31:0] s, input logic [3:0] t);
		@(posedge sys_clk);
		srcReq <= s;
		trapEvt <= t;
		@(posedge sys_clk);
		srcReq <= '0;
		trapEvt <= '0;
	endtask : pulse

	// Core loads its level; the level bus carries junk afterwards
	task automatic loadLevel(input logic [3:0] l);
		@(posedge sys_clk);
		cpuLevelWr <= 1'b1;
		cpuLevelIn <= l;
		@(posedge sys_clk);
		cpuLevelWr <= 1'b0;
		cpuLevelIn <= ~l;
	endtask : loadLevel

	task automatic setLines(input logic [2:0] p, input logic d);
		@(posedge sys_clk);
		extPin <= p;
		disableInstrActive <= d;
	endtask : setLines
endmodule : cpu_periph_model

// ==== dv/tb.sv ====
`timescale 1ns/1ns
module tb;
	logic                    sys_clk = 1'b0;
	logic                    rst_n = 1'b0;
	irq_prio_pkg::bus_req_t  bus = '0;
	logic [31:0]             srcReq;
	logic [3:0]              trapEvt;
	logic                    cpuLevelWr;
	logic [3:0]              cpuLevelIn;
	logic                    disableInstrActive;
	logic [2:0]              extPin;
	irq_prio_pkg::dispatch_t dispatch_q;
	logic [15:0]             rdData_q;
	logic                    irq_q;
	logic                    altTable_q;
	logic                    nestDisable_q;
	int                      failures = 0;
	int                      total_checks = 0;
	int                      cycles = 0;
	logic [7:0]              seed = 8'h3e;
	logic [4:0]              src;
	logic [2:0]              pr;
	logic [2:0]              lv;
	logic                    en;
	logic                    pend;
	logic [7:0]              zeroAdr [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h11, 8'h20};

	interrupt_priority_control #(.NUM_SRC(32)) u_interrupt_priority_control (
		.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .srcReq(srcReq), .extPin(extPin),
		.trapEvt(trapEvt), .cpuLevelWr(cpuLevelWr), .cpuLevelIn(cpuLevelIn),
		.disableInstrActive(disableInstrActive), .dispatch_q(dispatch_q),
		.rdData_q(rdData_q), .irq_q(irq_q), .altTable_q(altTable_q),
		.nestDisable_q(nestDisable_q));

	cpu_periph_model u_cpu_periph_model (
		.sys_clk(sys_clk), .srcReq(srcReq), .trapEvt(trapEvt), .cpuLevelWr(cpuLevelWr),
		.cpuLevelIn(cpuLevelIn), .disableInstrActive(disableInstrActive), .extPin(extPin));

	always #50 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	function automatic logic expPend(input logic e, input logic [2:0] p, input logic [3:0] l);
		return e && ({1'b0, p} > l);
	endfunction : expPend

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus <= '0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus <= '0;
		#1;
		chk($sformatf("read %h", a), exp, rdData_q);
	endtask : rd

	task automatic final_report();
		if (failures == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		foreach (zeroAdr[i]) rd(zeroAdr[i], 16'h0000);
		chk("outputs", 16'h0000, {12'h0, irq_q, altTable_q, nestDisable_q, dispatch_q.pending});
		wr(irq_prio_pkg::ADR_GCTRL_ONE, 16'hffff);
		rd(irq_prio_pkg::ADR_GCTRL_ONE, 16'h801e);
		chk("nest", 16'h0001, {15'h0, nestDisable_q});
		wr(irq_prio_pkg::ADR_STATUS_WORD, 16'h00e0);
		rd(irq_prio_pkg::ADR_STATUS_WORD, 16'h0000);
		wr(irq_prio_pkg::ADR_GCTRL_ONE, 16'h0000);
		wr(irq_prio_pkg::ADR_STATUS_WORD, 16'hffff);
		rd(irq_prio_pkg::ADR_STATUS_WORD, 16'h00e0);
		wr(irq_prio_pkg::ADR_CORE_CTRL, 16'hffff);
		rd(irq_prio_pkg::ADR_CORE_CTRL, 16'h0000);
		u_cpu_periph_model.loadLevel(4'h9);
		rd(irq_prio_pkg::ADR_CORE_CTRL, 16'h0008);
		rd(irq_prio_pkg::ADR_STATUS_WORD, 16'h0020);
		wr(irq_prio_pkg::ADR_CORE_CTRL, 16'h0000);
		rd(irq_prio_pkg::ADR_CORE_CTRL, 16'h0000);
		wr(irq_prio_pkg::ADR_GCTRL_TWO, 16'hffff);
		chk("alt table", 16'h0001, {15'h0, altTable_q});
		rd(irq_prio_pkg::ADR_GCTRL_TWO, 16'h8007);
		u_cpu_periph_model.setLines(3'h0, 1'b1);
		rd(irq_prio_pkg::ADR_GCTRL_TWO, 16'hc007);
		u_cpu_periph_model.setLines(3'h0, 1'b0);
		wr(irq_prio_pkg::ADR_GCTRL_TWO, 16'h0001);
		wr(irq_prio_pkg::ADR_EVT_MASK, 16'h0008);
		for (int k = 0; k < 4; k++) begin
			u_cpu_periph_model.pulse(32'h0, 4'h1 << k);
			@(posedge sys_clk);
			#1;
			chk("irq raised", {15'h0, k == 3}, {15'h0, irq_q});
			rd(irq_prio_pkg::ADR_GCTRL_ONE, 16'h0002 << k);
			rd(irq_prio_pkg::ADR_EVT_STATUS, 16'h0001 << k);
			chk("irq cleared", 16'h0000, {15'h0, irq_q});
			wr(irq_prio_pkg::ADR_GCTRL_ONE, 16'h0000);
		end
		u_cpu_periph_model.setLines(3'h7, 1'b0);
		repeat (4) @(posedge sys_clk);
		u_cpu_periph_model.setLines(3'h0, 1'b0);
		repeat (4) @(posedge sys_clk);
		rd(irq_prio_pkg::ADR_FLAG_BASE, 16'h0001);
		rd(irq_prio_pkg::ADR_FLAG_BASE + 8'h01, 16'h2010);
		rd(irq_prio_pkg::ADR_EVT_STATUS, 16'h0070);
		for (int n = 0; n < 16; n++) begin
			seed = lfsr(seed);
			src = seed[4:0];
			seed = lfsr(seed);
			pr = (seed[2:0] == 3'h0) ? 3'h1 : seed[2:0];
			lv = seed[5:3];
			en = seed[7] | seed[6];
			if (n == 0) begin
				src = 5'd31;
				pr = 3'h7;
				lv = 3'h6;
				en = 1'b1;
			end
			for (int a = 4; a < 16; a++) wr(8'(a), 16'h0000);
			wr(irq_prio_pkg::ADR_PRIO_BASE + {5'h0, src[4:2]}, {13'h0, pr} << {src[1:0], 2'b00});
			wr(irq_prio_pkg::ADR_ENABLE_BASE + {7'h0, src[4]}, {15'h0, en} << src[3:0]);
			wr(irq_prio_pkg::ADR_STATUS_WORD, {8'h0, lv, 5'h0});
			u_cpu_periph_model.pulse(32'h1 << src, 4'h0);
			repeat (2) @(posedge sys_clk);
			#1;
			pend = expPend(en, pr, {1'b0, lv});
			chk("pending", {15'h0, pend}, {15'h0, dispatch_q.pending});
			if (pend) chk("dispatch", {5'h0, 1'b1, 2'b00, src, pr}, {5'h0, dispatch_q});
			rd(irq_prio_pkg::ADR_FLAG_BASE + {7'h0, src[4]}, 16'h0001 << src[3:0]);
		end
		// Equal priorities go to the lower vector, a higher one overtakes
		for (int a = 4; a < 16; a++) wr(8'(a), 16'h0000);
		wr(irq_prio_pkg::ADR_PRIO_BASE + 8'h01, 16'h0040);
		wr(irq_prio_pkg::ADR_PRIO_BASE + 8'h02, 16'h0040);
		wr(irq_prio_pkg::ADR_ENABLE_BASE, 16'h0220);
		wr(irq_prio_pkg::ADR_STATUS_WORD, 16'h0000);
		u_cpu_periph_model.pulse(32'h0000_0220, 4'h0);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("tie dispatch", {5'h0, 1'b1, 7'h05, 3'h4}, {5'h0, dispatch_q});
		wr(irq_prio_pkg::ADR_PRIO_BASE + 8'h02, 16'h0060);
		@(posedge sys_clk);
		#1;
		chk("higher dispatch", {5'h0, 1'b1, 7'h09, 3'h6}, {5'h0, dispatch_q});
		u_cpu_periph_model.loadLevel(4'h6);
		@(posedge sys_clk);
		#1;
		chk("core level mask", 16'h0000, {15'h0, dispatch_q.pending});
		final_report();
	end
endmodule : tb
